// >>> design/ccpu_defines.vh
// constants of the capture/compare/pwm unit: register map, field layout,
// reset values and mode codes.
// assumes inclusion by bare name from the unit's design file.
`ifndef CCPU_DEFINES_VH
`define CCPU_DEFINES_VH

// register indices; byte address is four times the index
`define CCPU_IDX_VAL_LO    10'h015
`define CCPU_IDX_VAL_HI    10'h016
`define CCPU_IDX_CTRL      10'h017
`define CCPU_IDX_FLAG      10'h00c
`define CCPU_IDX_IRQ_EN    10'h08c
`define CCPU_ADDR_W        12

// control register fields
`define CCPU_MODE_HI       3
`define CCPU_MODE_LO       0
`define CCPU_DUTY_LO_HI    5
`define CCPU_DUTY_LO_LO    4
`define CCPU_CTRL_MASK     8'h3f
`define CCPU_CTRL_RESET    8'h00

// flag and enable bit position in their registers
`define CCPU_EVENT_BIT     2
`define CCPU_VAL_RESET     8'h00

// mode codes and mode classes (upper two bits)
`define CCPU_MODE_OFF      4'h0
`define CCPU_MODE_CAP_FALL 2'b00
`define CCPU_MODE_CAP_RISE 2'b01
`define CCPU_MODE_CAP_4TH  2'b10
`define CCPU_MODE_CAP_16TH 2'b11
`define CCPU_MODE_CMP_SET  4'h8
`define CCPU_MODE_CMP_CLR  4'h9
`define CCPU_MODE_CMP_SW   4'ha
`define CCPU_MODE_CMP_TRIG 4'hb
`define CCPU_CLASS_CAP     2'b01
`define CCPU_CLASS_CMP     2'b10
`define CCPU_CLASS_PWM     2'b11

// prescaler terminal counts
`define CCPU_PRESC_4TH     2'h3
`define CCPU_PRESC_16TH    4'hf

// one step of the extended timer two count
`define CCPU_T2_STEP       10'h001

// axi responses
`define CCPU_RESP_OKAY     2'b00
`define CCPU_RESP_SLVERR   2'b10

`endif

// >>> design/ccpu_unit.v
// capture/compare/pwm unit with an axi4-lite register slave.
// assumes timer one, timer two and the port pin live outside; their
// counts arrive synchronous to CLK and the pin input is an ordinary level.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_defines.vh"

module ccpu_unit #(
  parameter VAL_W  = 16,
  parameter PRESC_W = 4
) (
  // clock and reset
  input  wire                    CLK,
  input  wire                    RST,
  // axi4-lite write address
  input  wire [`CCPU_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire [2:0]              S_AXI_AWPROT,
  input  wire                    S_AXI_AWVALID,
  output wire                    S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0]             S_AXI_WDATA,
  input  wire [3:0]              S_AXI_WSTRB,
  input  wire                    S_AXI_WVALID,
  output wire                    S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0]              S_AXI_BRESP,
  output wire                    S_AXI_BVALID,
  input  wire                    S_AXI_BREADY,
  // axi4-lite read address
  input  wire [`CCPU_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire [2:0]              S_AXI_ARPROT,
  input  wire                    S_AXI_ARVALID,
  output wire                    S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0]             S_AXI_RDATA,
  output wire [1:0]              S_AXI_RRESP,
  output wire                    S_AXI_RVALID,
  input  wire                    S_AXI_RREADY,
  // unit pin
  input  wire                    UNIT_PIN_IN,
  output wire                    UNIT_PIN_OUT,
  // timer one
  input  wire [VAL_W-1:0]        TIMER_ONE_COUNT,
  output wire                    TIMER_ONE_RESET,
  // timer two
  input  wire [7:0]              TIMER_TWO_COUNT,
  input  wire [7:0]              TIMER_TWO_PERIOD,
  input  wire [1:0]              TIMER_TWO_FINE,
  input  wire                    TIMER_TWO_TICK,
  output wire                    TIMER_TWO_CLEAR,
  // event request
  output wire                    UNIT_EVENT_IRQ
);

  // byte address of a register index
  function [`CCPU_ADDR_W-1:0] byte_addr;
    input [9:0] idx;
    begin
      byte_addr = {idx, 2'b00};
    end
  endfunction

  // registers
  reg  [7:0]         val_lo_q;
  reg  [7:0]         val_lo_d;
  reg  [7:0]         val_hi_q;
  reg  [7:0]         val_hi_d;
  reg  [7:0]         ctrl_q;
  reg  [7:0]         ctrl_d;
  reg                flag_q;
  reg                flag_d;
  reg                irq_en_q;
  reg                irq_en_d;
  reg  [1:0]         fine_shadow_q;
  reg  [1:0]         fine_shadow_d;
  reg  [PRESC_W-1:0] presc_q;
  reg  [PRESC_W-1:0] presc_d;
  reg                out_q;
  reg                out_d;
  reg                match_q;
  reg                trig_q;
  reg                t2_clr_q;
  reg                pin_s1_q;
  reg                pin_s2_q;
  reg                pin_prev_q;

  // bus slave state
  reg                    aw_have_q;
  reg [`CCPU_ADDR_W-1:0] aw_addr_q;
  reg                    w_have_q;
  reg [7:0]              w_data_q;
  reg                    w_strb_q;
  reg                    bvalid_q;
  reg [1:0]              bresp_q;
  reg                    rvalid_q;
  reg [31:0]             rdata_q;
  reg [1:0]              rresp_q;

  wire [3:0] mode     = ctrl_q[`CCPU_MODE_HI:`CCPU_MODE_LO];
  wire       is_off   = (mode == `CCPU_MODE_OFF);
  wire       is_cap   = (mode[3:2] == `CCPU_CLASS_CAP);
  wire       is_cmp   = (mode[3:2] == `CCPU_CLASS_CMP);
  wire       is_pwm   = (mode[3:2] == `CCPU_CLASS_PWM);

  // pin edge detection on the synchronised level only
  wire pin_rise = pin_s2_q & ~pin_prev_q;
  wire pin_fall = ~pin_s2_q & pin_prev_q;

  // capture event select; the pin is observed whatever its direction
  reg cap_evt;
  always @* begin
    cap_evt = 1'b0;
    if (is_cap) begin
      case (mode[1:0])
        `CCPU_MODE_CAP_FALL: cap_evt = pin_fall;
        `CCPU_MODE_CAP_RISE: cap_evt = pin_rise;
        `CCPU_MODE_CAP_4TH:  cap_evt = pin_rise & (presc_q[1:0] == `CCPU_PRESC_4TH);
        `CCPU_MODE_CAP_16TH: cap_evt = pin_rise & (presc_q == `CCPU_PRESC_16TH);
        default:             cap_evt = 1'b0;
      endcase
    end
  end

  // compare acts once on the cycle the match begins, so a timer that
  // stops on the value does not retrigger the special event every cycle
  wire match_now = is_cmp & ({val_hi_q, val_lo_q} == TIMER_ONE_COUNT);
  wire cmp_hit   = match_now & ~match_q;

  // pwm timing
  wire [9:0] duty      = {val_lo_q, ctrl_q[`CCPU_DUTY_LO_HI:`CCPU_DUTY_LO_LO]};
  wire       pwm_roll  = is_pwm & TIMER_TWO_TICK & (TIMER_TWO_COUNT == TIMER_TWO_PERIOD);
  // the output latch is registered, so the match looks one step ahead and the
  // pin drops as the count reaches the duty; assumes one count step per clock
  wire [9:0] t2_ext_next = {TIMER_TWO_COUNT, TIMER_TWO_FINE} + `CCPU_T2_STEP;
  wire       pwm_match = is_pwm & ({val_hi_q, fine_shadow_q} == t2_ext_next);

  // bus decode
  wire wr_go   = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_en   = wr_go & w_strb_q;
  wire wr_lo   = wr_en & (aw_addr_q == byte_addr(`CCPU_IDX_VAL_LO));
  wire wr_hi   = wr_en & (aw_addr_q == byte_addr(`CCPU_IDX_VAL_HI));
  wire wr_ctrl = wr_en & (aw_addr_q == byte_addr(`CCPU_IDX_CTRL));
  wire wr_flag = wr_en & (aw_addr_q == byte_addr(`CCPU_IDX_FLAG));
  wire wr_ien  = wr_en & (aw_addr_q == byte_addr(`CCPU_IDX_IRQ_EN));
  wire wr_map  = (aw_addr_q == byte_addr(`CCPU_IDX_VAL_LO)) |
                 (aw_addr_q == byte_addr(`CCPU_IDX_VAL_HI)) |
                 (aw_addr_q == byte_addr(`CCPU_IDX_CTRL)) |
                 (aw_addr_q == byte_addr(`CCPU_IDX_FLAG)) |
                 (aw_addr_q == byte_addr(`CCPU_IDX_IRQ_EN));
  wire ctrl_zero_wr = wr_ctrl & ((w_data_q & `CCPU_CTRL_MASK) == `CCPU_CTRL_RESET);
  wire ar_go   = S_AXI_ARVALID & ~rvalid_q;

  // register next state
  always @* begin
    val_lo_d      = val_lo_q;
    val_hi_d      = val_hi_q;
    ctrl_d        = ctrl_q;
    flag_d        = flag_q;
    irq_en_d      = irq_en_q;
    fine_shadow_d = fine_shadow_q;
    if (wr_lo)
      val_lo_d = w_data_q;
    if (wr_hi & ~is_pwm)
      val_hi_d = w_data_q;
    if (wr_ctrl)
      ctrl_d = w_data_q & `CCPU_CTRL_MASK;
    if (wr_ien)
      irq_en_d = w_data_q[`CCPU_EVENT_BIT];
    // capture beats a software write to the value bytes, last capture wins
    if (cap_evt)
      {val_hi_d, val_lo_d} = TIMER_ONE_COUNT;
    if (pwm_roll) begin
      val_hi_d      = val_lo_q;
      fine_shadow_d = ctrl_q[`CCPU_DUTY_LO_HI:`CCPU_DUTY_LO_LO];
    end
    if (is_off)
      fine_shadow_d = 2'b00;
    // software writes the flag; a hardware event in that cycle wins
    if (wr_flag)
      flag_d = w_data_q[`CCPU_EVENT_BIT];
    if (cap_evt | cmp_hit)
      flag_d = 1'b1;
  end

  // prescaler: kept across capture-to-capture switches, cleared otherwise
  always @* begin
    presc_d = presc_q;
    if (~is_cap)
      presc_d = {PRESC_W{1'b0}};
    else if (pin_rise)
      presc_d = presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
  end

  // output latch shared by compare and pwm
  always @* begin
    out_d = out_q;
    if (is_cmp & cmp_hit) begin
      if (mode == `CCPU_MODE_CMP_SET)
        out_d = 1'b1;
      else if (mode == `CCPU_MODE_CMP_CLR)
        out_d = 1'b0;
    end
    if (pwm_match)
      out_d = 1'b0;
    if (pwm_roll)
      out_d = (duty != 10'h000);
    if (is_off | ctrl_zero_wr)
      out_d = 1'b0;
  end

  always @(posedge CLK) begin
    if (RST) begin
      val_lo_q      <= `CCPU_VAL_RESET;
      val_hi_q      <= `CCPU_VAL_RESET;
      ctrl_q        <= `CCPU_CTRL_RESET;
      flag_q        <= 1'b0;
      irq_en_q      <= 1'b0;
      fine_shadow_q <= 2'b00;
      presc_q       <= {PRESC_W{1'b0}};
      out_q         <= 1'b0;
      match_q       <= 1'b0;
      trig_q        <= 1'b0;
      t2_clr_q      <= 1'b0;
      pin_s1_q      <= 1'b0;
      pin_s2_q      <= 1'b0;
      pin_prev_q    <= 1'b0;
    end else begin
      val_lo_q      <= val_lo_d;
      val_hi_q      <= val_hi_d;
      ctrl_q        <= ctrl_d;
      flag_q        <= flag_d;
      irq_en_q      <= irq_en_d;
      fine_shadow_q <= fine_shadow_d;
      presc_q       <= presc_d;
      out_q         <= out_d;
      match_q       <= match_now;
      trig_q        <= cmp_hit & (mode == `CCPU_MODE_CMP_TRIG);
      t2_clr_q      <= pwm_roll;
      pin_s1_q      <= UNIT_PIN_IN;
      pin_s2_q      <= pin_s1_q;
      pin_prev_q    <= pin_s2_q;
    end
  end

  // axi4-lite write path: address and data taken in either order
  always @(posedge CLK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= {`CCPU_ADDR_W{1'b0}};
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CCPU_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID & ~aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[`CCPU_ADDR_W-1:2], 2'b00};
      end
      if (S_AXI_WVALID & ~w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA[7:0];
        w_strb_q <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? `CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
      end else if (bvalid_q & S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read mux; reserved bits read zero
  reg [7:0] rd_byte;
  reg       rd_map;
  always @* begin
    rd_byte = 8'h00;
    rd_map  = 1'b1;
    case ({S_AXI_ARADDR[`CCPU_ADDR_W-1:2], 2'b00})
      byte_addr(`CCPU_IDX_VAL_LO): rd_byte = val_lo_q;
      byte_addr(`CCPU_IDX_VAL_HI): rd_byte = val_hi_q;
      byte_addr(`CCPU_IDX_CTRL):   rd_byte = ctrl_q;
      byte_addr(`CCPU_IDX_FLAG):   rd_byte[`CCPU_EVENT_BIT] = flag_q;
      byte_addr(`CCPU_IDX_IRQ_EN): rd_byte[`CCPU_EVENT_BIT] = irq_en_q;
      default:                     rd_map = 1'b0;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `CCPU_RESP_OKAY;
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_map ? `CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
    end else if (rvalid_q & S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_AWREADY   = ~aw_have_q;
  assign S_AXI_WREADY    = ~w_have_q;
  assign S_AXI_BVALID    = bvalid_q;
  assign S_AXI_BRESP     = bresp_q;
  assign S_AXI_ARREADY   = ~rvalid_q;
  assign S_AXI_RVALID    = rvalid_q;
  assign S_AXI_RDATA     = rdata_q;
  assign S_AXI_RRESP     = rresp_q;
  assign UNIT_PIN_OUT    = out_q;
  assign TIMER_ONE_RESET = trig_q;
  assign TIMER_TWO_CLEAR = t2_clr_q;
  assign UNIT_EVENT_IRQ  = flag_q & irq_en_q;

endmodule // ccpu_unit

`default_nettype wire

// >>> test/ccpu_unit_assertions.sv
// checker on the unit ports: bus holds, reset state, timer pulses.
// assumes it is bound onto ccpu_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ccpu_unit_assertions (
  // clock and reset
  input wire        CLK,
  input wire        RST,
  // register bus
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  // pin and timers
  input wire        UNIT_PIN_OUT,
  input wire        TIMER_ONE_RESET,
  input wire [7:0]  TIMER_TWO_COUNT,
  input wire [7:0]  TIMER_TWO_PERIOD,
  input wire        TIMER_TWO_TICK,
  input wire        TIMER_TWO_CLEAR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence b_wait_s; S_AXI_BVALID && !S_AXI_BREADY; endsequence
  sequence r_wait_s; S_AXI_RVALID && !S_AXI_RREADY; endsequence
  sequence roll_s; TIMER_TWO_TICK && TIMER_TWO_COUNT == TIMER_TWO_PERIOD; endsequence
  resp_hold_a: assert property (b_wait_s |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer not held");
  rdata_hold_a: assert property (r_wait_s |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer not held");
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read upper bits set");
  ar_ready_a: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address ready wrong");
  reset_idle_a: assert property (@(posedge CLK) disable iff (1'b0)
    RST |=> !S_AXI_BVALID && !S_AXI_RVALID && !UNIT_PIN_OUT && !TIMER_ONE_RESET)
    else $error("outputs active after reset");
  trig_pulse_a: assert property (TIMER_ONE_RESET |=> !TIMER_ONE_RESET)
    else $error("trigger longer than one cycle");
  clear_cause_a: assert property (TIMER_TWO_CLEAR |-> $past(TIMER_TWO_TICK) &&
    $past(TIMER_TWO_COUNT) == $past(TIMER_TWO_PERIOD))
    else $error("timer two clear without roll");
  clear_pulse_a: assert property (roll_s ##1 TIMER_TWO_CLEAR |=> !TIMER_TWO_CLEAR)
    else $error("timer two clear too long");
endmodule // ccpu_unit_assertions
bind ccpu_unit ccpu_unit_assertions ccpu_unit_assertions_inst (.CLK, .RST,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_RREADY, .S_AXI_RDATA, .UNIT_PIN_OUT, .TIMER_ONE_RESET, .TIMER_TWO_COUNT,
  .TIMER_TWO_PERIOD, .TIMER_TWO_TICK, .TIMER_TWO_CLEAR);
`default_nettype wire

// >>> test/ccpu_far_side.sv
// far-side model: timer one and timer two with two fine bits.
// assumes the unit's clock; timer one counts synchronously only.
`timescale 1ns/1ps
`default_nettype none
module ccpu_far_side (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // timer one
  input  wire         t1_reset,
  output logic [15:0] t1_count,
  // timer two
  input  wire  [7:0]  t2_period,
  output logic [7:0]  t2_count,
  output logic [1:0]  t2_fine,
  output logic        t2_tick
);
  // fine bits are sub-steps, so one tick every four cycles
  assign t2_tick = t2_fine == 2'h3;
  always @(posedge clk) begin
    if (rst || t1_reset)
      t1_count <= 16'h0000;
    else
      t1_count <= t1_count + 16'h0001;
    if (rst)
      t2_fine <= 2'h0;
    else
      t2_fine <= t2_fine + 2'h1;
    if (rst || (t2_tick && t2_count == t2_period))
      t2_count <= 8'h00;
    else if (t2_tick)
      t2_count <= t2_count + 8'h01;
  end
endmodule // ccpu_far_side
`default_nettype wire

// >>> test/ccpu_unit_bench.sv
// bench for ccpu_unit: register bus, capture, compare and pwm scenarios.
// assumes the far-side model for the timers; the bench drives the pin.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_defines.vh"
module ccpu_unit_bench;
  localparam logic [11:0] A_LO = 12'h054, A_HI = 12'h058, A_CT = 12'h05c;
  localparam logic [11:0] A_FL = 12'h030, A_EN = 12'h230;
  logic        clk = 1'b0, rst = 1'b1, pin = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000, rdv;
  logic [7:0]  pr = 8'h09;
  logic [1:0]  resp;
  logic [15:0] t0, v;
  wire         awr, wrd, bv, arr, rv, pout, t1r, t2c, t2t, irq;
  wire  [1:0]  br, rr, t2f;
  wire  [31:0] rdat;
  wire  [15:0] t1;
  wire  [7:0]  t2;
  int          errors = 0, total_checks = 0, cyc = 0, k;
  ccpu_unit ccpu_unit_inst (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrdy), .UNIT_PIN_IN(pin), .UNIT_PIN_OUT(pout), .TIMER_ONE_COUNT(t1),
    .TIMER_ONE_RESET(t1r), .TIMER_TWO_COUNT(t2), .TIMER_TWO_PERIOD(pr),
    .TIMER_TWO_FINE(t2f), .TIMER_TWO_TICK(t2t), .TIMER_TWO_CLEAR(t2c),
    .UNIT_EVENT_IRQ(irq));
  ccpu_far_side ccpu_far_side_inst (.clk(clk), .rst(rst), .t1_reset(t1r),
    .t1_count(t1), .t2_period(pr), .t2_count(t2), .t2_fine(t2f), .t2_tick(t2t));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end
  task ck(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    brdy <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rdv = rdat;
    resp = rr;
    rrdy <= 1'b0;
  endtask
  // the pin acts as an input here t0 holds timer one at the edge of interest
  task pulse(input logic fall);
    @(posedge clk);
    pin <= 1'b1;
    t0 = t1;
    repeat (6) @(posedge clk);
    pin <= 1'b0;
    if (fall) t0 = t1;
    repeat (6) @(posedge clk);
  endtask
  task t_regs();
    rd(A_CT);
    ck(rdv === 32'h00000000 && resp === `CCPU_RESP_OKAY, "control reset");
    wr(A_CT, 8'hff);
    rd(A_CT);
    ck(rdv === 32'h0000003f, "control mask");
    wr(A_CT, 8'h00);
    wr(A_HI, 8'ha5);
    rd(A_HI);
    ck(rdv === 32'h000000a5, "value high rw");
    wr(12'h100, 8'h11);
    ck(resp === `CCPU_RESP_SLVERR, "unmapped write");
    rd(12'h100);
    ck(rdv === 32'h0 && resp === `CCPU_RESP_SLVERR, "unmapped read");
    $display("test regs done");
  endtask
  task t_cap();
    logic [3:0] md [4] = '{4'h6, 4'h4, 4'h5, 4'h7};
    foreach (md[i]) begin
      wr(A_CT, 8'h00);
      wr(A_CT, {4'h0, md[i]});
      wr(A_FL, 8'h00);
      repeat (md[i] == 4'h6 ? 4 : (md[i] == 4'h7 ? 16 : 1)) begin
        rd(A_FL);
        ck(rdv[2] === 1'b0, "early capture");
        pulse(md[i] == 4'h4);
      end
      rd(A_FL);
      ck(rdv[2] === 1'b1, "capture flag");
      rd(A_LO);
      v[7:0] = rdv[7:0];
      rd(A_HI);
      v[15:8] = rdv[7:0];
      ck((v - t0) <= 16'd8, "captured count");
    end
    $display("test capture done");
  endtask
  task t_cmp();
    logic [3:0] md [5] = '{4'h8, 4'ha, 4'h9, 4'h8, 4'hb};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic       hit;
    wr(A_EN, 8'h04);
    foreach (md[i]) begin
      v = t1 + 16'd120;
      wr(A_LO, v[7:0]);
      wr(A_HI, v[15:8]);
      wr(A_CT, {4'h0, md[i]});
      wr(A_FL, 8'h00);
      hit = 1'b0;
      repeat (200) begin
        @(posedge clk);
        hit = hit | (t1r === 1'b1);
      end
      rd(A_FL);
      ck(rdv[2] === 1'b1, "compare flag");
      if (md[i] != 4'hb) ck(pout === ex[i], "compare pin");
      else ck(hit && t1 < 16'd200, "special trigger");
      if (md[i] == 4'ha) ck(irq === 1'b1, "irq raised");
    end
    wr(A_EN, 8'h00);
    ck(irq === 1'b0, "irq masked");
    wr(A_FL, 8'h00);
    wr(A_CT, 8'h00);
    @(posedge clk);
    ck(pout === 1'b0, "compare latch cleared");
    $display("test compare done");
  endtask
  task t_pwm();
    logic [7:0] dl [3] = '{8'h00, 8'h03, 8'hff};
    int         hi [3] = '{0, 14, 40};
    foreach (dl[i]) begin
      wr(A_LO, dl[i]);
      wr(A_CT, i == 1 ? 8'h2c : 8'h0f);
      repeat (100) @(posedge clk);
      k = 0;
      repeat (40) begin
        @(posedge clk);
        if (pout === 1'b1) k++;
      end
      ck(k == hi[i], "pwm high time");
    end
    wr(A_HI, 8'h55);
    rd(A_HI);
    ck(rdv === 32'h000000ff, "pwm shadow");
    wr(A_CT, 8'h00);
    @(posedge clk);
    ck(pout === 1'b0, "pwm latch cleared");
    $display("test pwm done");
  endtask
  task final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cap();
    t_cmp();
    t_pwm();
    final_report();
  end
endmodule // ccpu_unit_bench
`default_nettype wire
